// >>> src/mbac_pkg.sv
// Package with address map, modes and register offsets for the access check.
package mbac_pkg;

  // ---------------------------------------------------------------
  // Modes and operation classes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MBAC_BOOT,
    MBAC_TEST,
    MBAC_FW,
    MBAC_SYS,
    MBAC_USER
  } mbac_mode_t;

  typedef enum logic [1:0] {
    MBAC_OP_READ,
    MBAC_OP_WRITE,
    MBAC_OP_EXEC
  } mbac_op_t;

  typedef enum logic [1:0] {
    MBAC_REQ_CPU,
    MBAC_REQ_COPY,
    MBAC_REQ_CRYPTO
  } mbac_src_t;

  // ---------------------------------------------------------------
  // Physical map (byte addresses, 16-bit physical space)
  // ---------------------------------------------------------------
  localparam logic [15:0] ROM_BASE = 16'h0000;
  localparam logic [15:0] ROM_TEST_END = 16'h0FFF;
  localparam logic [15:0] ROM_FW_END = 16'h1FFF;
  localparam logic [15:0] ROM_END = 16'h7FFF;
  localparam logic [15:0] EE_BASE = 16'h8000;
  localparam logic [15:0] EE_FW_END = 16'h87FF;
  localparam logic [15:0] EE_SEC_BASE = 16'h8800;
  localparam logic [15:0] EE_SEC_END = 16'h88FF;
  localparam logic [15:0] EE_END = 16'hDFFF;
  localparam logic [15:0] RAM_BASE = 16'hE000;
  localparam logic [15:0] RAM_FW_END = 16'hE3FF;
  localparam logic [15:0] RAM_CRY_BASE = 16'hF000;
  localparam logic [15:0] RAM_END = 16'hFFFF;

  // ---------------------------------------------------------------
  // Segment table
  // ---------------------------------------------------------------
  localparam int SEG_NUM = 64;
  localparam int SEG_IW = 6;

  // ---------------------------------------------------------------
  // Register offsets (word addresses of the plain port)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_DENY = 8'h01;
  localparam logic [7:0] REG_FWFW = 8'h02;
  localparam logic [7:0] REG_XBASL = 8'h03;
  localparam logic [7:0] REG_XBASH = 8'h04;
  localparam logic [7:0] REG_XSZL = 8'h05;
  localparam logic [7:0] REG_XSZH = 8'h06;
  localparam logic [7:0] REG_SEGSEL = 8'h07;
  localparam logic [7:0] REG_SEGFIRST = 8'h08;
  localparam logic [7:0] REG_SEGLAST = 8'h09;
  localparam logic [7:0] REG_SEGOFS = 8'h0A;
  localparam logic [7:0] REG_SEGRGT = 8'h0B;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  // Field positions and reset values.
  localparam int DENY_EE_ROM = 0;
  localparam int DENY_CP_ROM = 1;
  localparam int DENY_CP_EE = 2;
  localparam int FW_FROM_SYS = 3;
  localparam int RGT_R = 0;
  localparam int RGT_W = 1;
  localparam int RGT_X = 2;
  localparam int RGT_HW = 3;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // Register groups, carried in the upper nibble of a register address.
  localparam logic [3:0] GRP_MMU = 4'h0;
  localparam logic [3:0] GRP_SYSM = 4'h1;
  localparam logic [3:0] GRP_FWFW = 4'h2;
  localparam logic [3:0] GRP_FWOS = 4'h3;
  localparam logic [3:0] GRP_TEST = 4'h4;
  localparam logic [3:0] GRP_HW = 4'h5;
  localparam logic [3:0] GRP_CPU = 4'h6;
  localparam logic [3:0] GRP_CPUSU = 4'h7;
  localparam logic [7:0] SFR_RO = 8'h5E;
  localparam logic [7:0] SFR_NR = 8'h5F;

endpackage : mbac_pkg

// >>> src/mbac_top.sv
// Mode based memory and register access control unit.
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
// Contract
// - CPU addresses are virtual, translated before memory
// - Permission decided before access, denials blocked
// - Every register access checked against current mode
// - Hardware registers: segment rights or firewall
// - Refused register access raises exception
// - Single registers may block read or write
// - Decision uses mode, segments and configuration
// - Boot: test ROM, firmware EEPROM, firmware RAM
// - Test: whole ROM, EEPROM and RAM
// - Firmware: own ROM, firmware RAM
// - Firmware: whole EEPROM rw, firewall gates partition
// - System: application ROM, EEPROM, RAM
// - User: segment table grants application memory
// - Firmware: exchange window in application RAM
// - Boot and firmware may read security rows
// - Firmware called from system: application EEPROM rw
// - Crypto coprocessor owns its operand RAM
// - Three deny options for ROM and EEPROM reads
// - Five exclusive modes chosen by register
// - Segment entry: rights, bounds, offset, hw rights
// - Segment without rights matches nothing
module mbac_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Memory request
  input wire logic mem_req_i,
  input wire logic [15:0] mem_vaddr_i,
  input wire logic [1:0] mem_op_i,
  input wire logic [1:0] mem_src_i,
  input wire logic mem_code_in_ee_i,
  input wire logic [2:0] copy_mode_i,
  output logic mem_grant_o,
  output logic [15:0] mem_paddr_o,
  // Register access check
  input wire logic sfr_req_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  output logic sfr_grant_o,
  // Exception
  output logic exc_o
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  mbac_pkg::mbac_mode_t mode_r;
  logic [3:0] deny_r;
  logic [15:0] fwfw_r;
  logic [15:0] exchange_window_base_low_r;
  logic [15:0] exchange_window_base_high_r;
  logic [15:0] exchange_window_size_low_r;
  logic [15:0] exchange_window_size_high_r;
  logic [5:0] segsel_r;
  logic [15:0] seg_first_r [mbac_pkg::SEG_NUM];
  logic [15:0] seg_last_r [mbac_pkg::SEG_NUM];
  logic [15:0] seg_ofs_r [mbac_pkg::SEG_NUM];
  logic [3:0] seg_rgt_r [mbac_pkg::SEG_NUM];
  logic [5:0] cur_seg_r;
  logic cur_seg_hit_r;
  logic exc_sticky_r;

  // Mode writes take effect from the next access onward.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= mbac_pkg::MBAC_BOOT;
    end else if (reg_wr_i && reg_addr_i == mbac_pkg::REG_MODE) begin
      case (reg_wdata_i[2:0])
        3'h0: mode_r <= mbac_pkg::MBAC_BOOT;
        3'h1: mode_r <= mbac_pkg::MBAC_TEST;
        3'h2: mode_r <= mbac_pkg::MBAC_FW;
        3'h3: mode_r <= mbac_pkg::MBAC_SYS;
        3'h4: mode_r <= mbac_pkg::MBAC_USER;
        default: mode_r <= mode_r;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      deny_r <= 4'h0;
      fwfw_r <= mbac_pkg::DATA_RST;
      exchange_window_base_low_r <= mbac_pkg::DATA_RST;
      exchange_window_base_high_r <= mbac_pkg::DATA_RST;
      exchange_window_size_low_r <= mbac_pkg::DATA_RST;
      exchange_window_size_high_r <= mbac_pkg::DATA_RST;
      segsel_r <= 6'h00;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        mbac_pkg::REG_DENY: deny_r <= reg_wdata_i[3:0];
        mbac_pkg::REG_FWFW: fwfw_r <= reg_wdata_i;
        mbac_pkg::REG_XBASL: exchange_window_base_low_r <= reg_wdata_i;
        mbac_pkg::REG_XBASH: exchange_window_base_high_r <= reg_wdata_i;
        mbac_pkg::REG_XSZL: exchange_window_size_low_r <= reg_wdata_i;
        mbac_pkg::REG_XSZH: exchange_window_size_high_r <= reg_wdata_i;
        mbac_pkg::REG_SEGSEL: segsel_r <= reg_wdata_i[5:0];
        default: segsel_r <= segsel_r;
      endcase
    end
  end

  // Segment table, written through the selected index.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int i = 0; i < mbac_pkg::SEG_NUM; i++) begin
        seg_first_r[i] <= mbac_pkg::DATA_RST;
        seg_last_r[i] <= mbac_pkg::DATA_RST;
        seg_ofs_r[i] <= mbac_pkg::DATA_RST;
        seg_rgt_r[i] <= 4'h0;
      end
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        mbac_pkg::REG_SEGFIRST: seg_first_r[segsel_r] <= reg_wdata_i;
        mbac_pkg::REG_SEGLAST: seg_last_r[segsel_r] <= reg_wdata_i;
        mbac_pkg::REG_SEGOFS: seg_ofs_r[segsel_r] <= reg_wdata_i;
        mbac_pkg::REG_SEGRGT: seg_rgt_r[segsel_r] <= reg_wdata_i[3:0];
        default: seg_rgt_r[segsel_r] <= seg_rgt_r[segsel_r];
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Segment lookup
  // ---------------------------------------------------------------
  logic seg_hit;
  logic [5:0] seg_idx;
  always_comb begin
    seg_hit = 1'b0;
    seg_idx = 6'h00;
    for (int i = mbac_pkg::SEG_NUM - 1; i >= 0; i--) begin
      // A segment with no rights is disabled.
      if (seg_rgt_r[i][2:0] != 3'h0 && mem_vaddr_i >= seg_first_r[i] &&
          mem_vaddr_i <= seg_last_r[i]) begin
        seg_hit = 1'b1;
        seg_idx = 6'(i);
      end
    end
  end

  // ---------------------------------------------------------------
  // Memory permission
  // ---------------------------------------------------------------
  logic [15:0] paddr;
  logic in_rom, in_trom, in_from, in_arom;
  logic in_ee, in_fee, in_sec, in_aee;
  logic in_ram, in_fram, in_aram, in_cram, in_xwin;
  logic [31:0] xbase, xsize, xend;
  logic rd, wr, ex, mem_ok;
  mbac_pkg::mbac_mode_t eff_mode;

  always_comb begin
    // Translation: user code is relocated by its segment.
    if (mode_r == mbac_pkg::MBAC_USER && seg_hit) begin
      paddr = mem_vaddr_i + seg_ofs_r[seg_idx];
    end else begin
      paddr = mem_vaddr_i;
    end
  end

  // Copy engine keeps the mode it was started in.
  always_comb begin
    if (mem_src_i == 2'(mbac_pkg::MBAC_REQ_COPY) && copy_mode_i <= 3'h4) begin
      eff_mode = mbac_pkg::mbac_mode_t'(copy_mode_i);
    end else begin
      eff_mode = mode_r;
    end
  end

  assign in_rom = paddr <= mbac_pkg::ROM_END;
  assign in_trom = paddr <= mbac_pkg::ROM_TEST_END;
  assign in_from = in_rom && !in_trom && paddr <= mbac_pkg::ROM_FW_END;
  assign in_arom = in_rom && paddr > mbac_pkg::ROM_FW_END;
  assign in_ee = paddr >= mbac_pkg::EE_BASE && paddr <= mbac_pkg::EE_END;
  assign in_fee = in_ee && paddr <= mbac_pkg::EE_FW_END;
  assign in_aee = in_ee && paddr > mbac_pkg::EE_FW_END;
  assign in_sec = paddr >= mbac_pkg::EE_SEC_BASE &&
                  paddr <= mbac_pkg::EE_SEC_END;
  assign in_ram = paddr >= mbac_pkg::RAM_BASE;
  assign in_fram = in_ram && paddr <= mbac_pkg::RAM_FW_END;
  assign in_cram = paddr >= mbac_pkg::RAM_CRY_BASE;
  assign in_aram = in_ram && !in_fram;
  assign xbase = {exchange_window_base_high_r, exchange_window_base_low_r};
  assign xsize = {exchange_window_size_high_r, exchange_window_size_low_r};
  assign xend = xbase + xsize;
  assign in_xwin = in_aram && {16'h0000, paddr} >= xbase &&
                   {16'h0000, paddr} < xend;
  // Each operation class has its own permission bit.
  assign rd = mem_op_i == 2'(mbac_pkg::MBAC_OP_READ);
  assign wr = mem_op_i == 2'(mbac_pkg::MBAC_OP_WRITE);
  assign ex = mem_op_i == 2'(mbac_pkg::MBAC_OP_EXEC);

  // Allow rules; anything not covered stays denied.
  always_comb begin
    mem_ok = 1'b0;
    if (mem_src_i == 2'(mbac_pkg::MBAC_REQ_CRYPTO)) begin
      mem_ok = in_cram && !ex;
    end else begin
      case (eff_mode)
        mbac_pkg::MBAC_BOOT: begin
          mem_ok = (in_trom && !wr) || in_fee || (in_fram && !ex) ||
                   (in_sec && rd);
        end
        mbac_pkg::MBAC_TEST: begin
          mem_ok = (in_rom && !wr) || in_ee || (in_ram && !ex);
        end
        mbac_pkg::MBAC_FW: begin
          mem_ok = (in_from && !wr) || (in_fram && !ex) ||
                   (in_ee && !ex) ||
                   (in_fee && fwfw_r[mbac_pkg::RGT_X:0] != 3'h0 &&
                    fwfw_r[mem_op_i]) ||
                   (in_xwin && !ex) ||
                   (in_sec && rd) ||
                   (in_aee && !ex && deny_r[mbac_pkg::FW_FROM_SYS]);
        end
        mbac_pkg::MBAC_SYS: begin
          mem_ok = (in_arom && !wr) || in_aee || (in_aram && !ex);
        end
        mbac_pkg::MBAC_USER: begin
          mem_ok = seg_hit && seg_rgt_r[seg_idx][mem_op_i] &&
                   ((in_arom && !wr) || in_aee || (in_aram && !ex));
        end
        default: mem_ok = 1'b0;
      endcase
      // Configurable denials override the allow rules.
      if (rd && in_rom && mem_code_in_ee_i && deny_r[mbac_pkg::DENY_EE_ROM])
        mem_ok = 1'b0;
      if (mem_src_i == 2'(mbac_pkg::MBAC_REQ_COPY) && rd) begin
        if (in_rom && deny_r[mbac_pkg::DENY_CP_ROM]) mem_ok = 1'b0;
        if (in_ee && deny_r[mbac_pkg::DENY_CP_EE]) mem_ok = 1'b0;
      end
    end
    // The spare operation code would index the hardware right bit.
    if (!(rd || wr || ex)) mem_ok = 1'b0;
  end

  // ---------------------------------------------------------------
  // Register permission
  // ---------------------------------------------------------------
  logic [3:0] grp;
  logic sfr_ok;
  assign grp = sfr_addr_i[7:4];
  always_comb begin
    sfr_ok = 1'b0;
    case (grp)
      mbac_pkg::GRP_MMU: sfr_ok = mode_r == mbac_pkg::MBAC_SYS;
      mbac_pkg::GRP_SYSM: sfr_ok = mode_r inside {mbac_pkg::MBAC_BOOT,
                                   mbac_pkg::MBAC_TEST, mbac_pkg::MBAC_SYS};
      mbac_pkg::GRP_FWFW: sfr_ok = mode_r != mbac_pkg::MBAC_USER &&
                          (mode_r != mbac_pkg::MBAC_FW || !sfr_wr_i);
      mbac_pkg::GRP_FWOS: sfr_ok = mode_r inside {mbac_pkg::MBAC_BOOT,
                                   mbac_pkg::MBAC_TEST, mbac_pkg::MBAC_FW};
      mbac_pkg::GRP_TEST: sfr_ok = mode_r == mbac_pkg::MBAC_TEST;
      mbac_pkg::GRP_HW: begin
        case (mode_r)
          mbac_pkg::MBAC_FW: sfr_ok = fwfw_r[mbac_pkg::RGT_HW];
          mbac_pkg::MBAC_USER: sfr_ok = cur_seg_hit_r &&
                               seg_rgt_r[cur_seg_r][mbac_pkg::RGT_HW];
          default: sfr_ok = 1'b1;
        endcase
      end
      mbac_pkg::GRP_CPU: sfr_ok = 1'b1;
      mbac_pkg::GRP_CPUSU: sfr_ok = mode_r inside {mbac_pkg::MBAC_SYS,
                                    mbac_pkg::MBAC_USER};
      default: sfr_ok = 1'b0;
    endcase
    // Single registers that refuse one direction.
    if (sfr_addr_i == mbac_pkg::SFR_RO && sfr_wr_i) sfr_ok = 1'b0;
    if (sfr_addr_i == mbac_pkg::SFR_NR && !sfr_wr_i) sfr_ok = 1'b0;
  end

  // ---------------------------------------------------------------
  // Outputs, registered one cycle after the request
  // ---------------------------------------------------------------
  // Remember the segment of the last fetch for register rights.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cur_seg_r <= 6'h00;
      cur_seg_hit_r <= 1'b0;
    end else if (mem_req_i && ex && mem_src_i == 2'(mbac_pkg::MBAC_REQ_CPU)) begin
      cur_seg_r <= seg_idx;
      cur_seg_hit_r <= seg_hit;
    end
  end

  // Denied requests never reach memory; the address is withheld.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mem_grant_o <= 1'b0;
      mem_paddr_o <= mbac_pkg::DATA_RST;
    end else begin
      mem_grant_o <= mem_req_i && mem_ok;
      mem_paddr_o <= (mem_req_i && mem_ok) ? paddr : mbac_pkg::DATA_RST;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sfr_grant_o <= 1'b0;
      exc_o <= 1'b0;
    end else begin
      sfr_grant_o <= sfr_req_i && sfr_ok;
      exc_o <= (sfr_req_i && !sfr_ok) || (mem_req_i && !mem_ok);
    end
  end

  // A status bit keeps the last exception; set wins over the clearing read.
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      exc_sticky_r <= 1'b0;
    end else if ((sfr_req_i && !sfr_ok) || (mem_req_i && !mem_ok)) begin
      exc_sticky_r <= 1'b1;
    end else if (reg_rd_i && reg_addr_i == mbac_pkg::REG_STATUS) begin
      exc_sticky_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata_o <= mbac_pkg::DATA_RST;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        mbac_pkg::REG_MODE: reg_rdata_o <= {13'h0000, mode_r};
        mbac_pkg::REG_DENY: reg_rdata_o <= {12'h000, deny_r};
        mbac_pkg::REG_FWFW: reg_rdata_o <= fwfw_r;
        mbac_pkg::REG_XBASL: reg_rdata_o <= exchange_window_base_low_r;
        mbac_pkg::REG_XBASH: reg_rdata_o <= exchange_window_base_high_r;
        mbac_pkg::REG_XSZL: reg_rdata_o <= exchange_window_size_low_r;
        mbac_pkg::REG_XSZH: reg_rdata_o <= exchange_window_size_high_r;
        mbac_pkg::REG_SEGSEL: reg_rdata_o <= {10'h000, segsel_r};
        mbac_pkg::REG_SEGFIRST: reg_rdata_o <= seg_first_r[segsel_r];
        mbac_pkg::REG_SEGLAST: reg_rdata_o <= seg_last_r[segsel_r];
        mbac_pkg::REG_SEGOFS: reg_rdata_o <= seg_ofs_r[segsel_r];
        mbac_pkg::REG_SEGRGT: reg_rdata_o <= {12'h000, seg_rgt_r[segsel_r]};
        mbac_pkg::REG_STATUS: reg_rdata_o <= {8'h00, cur_seg_hit_r,
                                              exc_sticky_r, cur_seg_r};
        default: reg_rdata_o <= mbac_pkg::DATA_RST;
      endcase
    end else begin
      reg_rdata_o <= mbac_pkg::DATA_RST;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_r);

  a_grant_no_exc: assert property (
    mem_req_i && mem_ok && !(sfr_req_i && !sfr_ok) |=> !exc_o)
    else $error("memory grant with exception");
  a_deny_raises_exc: assert property (
    mem_req_i && !mem_ok |=> exc_o && !mem_grant_o)
    else $error("denied access not flagged");
  a_sfr_refuse_exc: assert property (
    sfr_req_i && !sfr_ok |=> exc_o && !sfr_grant_o)
    else $error("refused register access not flagged");
  a_mmu_sys_only: assert property (
    sfr_req_i && grp == mbac_pkg::GRP_MMU && mode_r != mbac_pkg::MBAC_SYS
    |=> !sfr_grant_o)
    else $error("mmu group granted outside system mode");
  a_ro_reg_write: assert property (
    sfr_req_i && sfr_wr_i && sfr_addr_i == mbac_pkg::SFR_RO |=> exc_o)
    else $error("read only register written");
  a_user_seg_only: assert property (
    mem_req_i && mode_r == mbac_pkg::MBAC_USER && !seg_hit &&
    mem_src_i == 2'(mbac_pkg::MBAC_REQ_CPU) |=> !mem_grant_o)
    else $error("user access without segment granted");
  a_ram_no_exec: assert property (
    mem_req_i && ex && in_ram |=> !mem_grant_o)
    else $error("execute from ram granted");
  a_copy_rom_deny: assert property (
    mem_req_i && rd && in_rom && deny_r[mbac_pkg::DENY_CP_ROM] &&
    mem_src_i == 2'(mbac_pkg::MBAC_REQ_COPY) |=> !mem_grant_o)
    else $error("copy engine read rom despite deny");
  a_paddr_follows: assert property (
    mem_req_i && mem_ok |=> mem_paddr_o == $past(paddr))
    else $error("physical address mismatch");
  a_test_ram_ok: assert property (
    mem_req_i && mode_r == mbac_pkg::MBAC_TEST && in_ram && rd &&
    mem_src_i == 2'(mbac_pkg::MBAC_REQ_CPU) |=> mem_grant_o)
    else $error("test mode ram read refused");

  c_user_grant: cover property (mode_r == mbac_pkg::MBAC_USER && mem_grant_o);
  c_fw_window: cover property (mem_req_i && mode_r == mbac_pkg::MBAC_FW &&
                               in_xwin ##1 mem_grant_o);
  c_sfr_refuse: cover property (sfr_req_i && !sfr_ok ##1 exc_o);
  c_crypto: cover property (mem_src_i == 2'(mbac_pkg::MBAC_REQ_CRYPTO) &&
                            mem_req_i ##1 mem_grant_o);

endmodule : mbac_top

// >>> verif/mbac_cpu_model.sv
// CPU core model issuing memory and register check requests.
`timescale 1ns/100ps
module mbac_cpu_model (
  // Clock
  input wire logic clock_i,
  // Memory request
  output logic mem_req_o,
  output logic [15:0] mem_vaddr_o,
  output logic [1:0] mem_op_o,
  output logic [1:0] mem_src_o,
  // Register check request
  output logic sfr_req_o,
  output logic [7:0] sfr_addr_o,
  output logic sfr_wr_o
);
  initial begin
    mem_req_o = 1'b0;
    mem_vaddr_o = 16'h0000;
    mem_op_o = 2'h0;
    mem_src_o = 2'h0;
    sfr_req_o = 1'b0;
    sfr_addr_o = 8'h00;
    sfr_wr_o = 1'b0;
  end
  // Idle lines flip so a stale address never looks like a live one.
  task automatic idle();
    @(posedge clock_i);
    mem_req_o <= 1'b0;
    sfr_req_o <= 1'b0;
    mem_vaddr_o <= ~mem_vaddr_o;
    sfr_addr_o <= ~sfr_addr_o;
  endtask : idle
  // Only virtual addresses leave the core.
  task automatic mem(input logic [15:0] a, input logic [1:0] op,
                     input logic [1:0] src);
    @(posedge clock_i);
    mem_req_o <= 1'b1;
    sfr_req_o <= 1'b0;
    mem_vaddr_o <= a;
    mem_op_o <= op;
    mem_src_o <= src;
  endtask : mem
  task automatic sfr(input logic [7:0] a, input logic wr);
    @(posedge clock_i);
    mem_req_o <= 1'b0;
    sfr_req_o <= 1'b1;
    sfr_addr_o <= a;
    sfr_wr_o <= wr;
  endtask : sfr
endmodule : mbac_cpu_model

// >>> verif/tb.sv
// Self-checking bench for the access check unit.
`timescale 1ns/100ps
module tb;
  localparam logic [1:0] OR = 2'h0, OW = 2'h1, OX = 2'h2;
  localparam logic [1:0] CP = 2'h0, CY = 2'h1, CR = 2'h2;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic code_ee = 1'b0;
  logic rd_d = 1'b0;
  logic [15:0] rdata, paddr, vaddr, ofs;
  logic mreq, mgnt, sreq, sgnt, swr, exc;
  logic [1:0] op, src;
  logic [7:0] saddr, r;
  logic [18:0] note_q[$];
  logic [15:0] rd_q[$];
  int n_mismatch = 0;
  int checks_done = 0;
  always #2.5 clock_i = ~clock_i;
  mbac_cpu_model mbac_cpu_model_inst (.clock_i(clock_i), .mem_req_o(mreq),
    .mem_vaddr_o(vaddr), .mem_op_o(op), .mem_src_o(src), .sfr_req_o(sreq),
    .sfr_addr_o(saddr), .sfr_wr_o(swr));
  mbac_top mbac_top_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .mem_req_i(mreq),
    .mem_vaddr_i(vaddr), .mem_op_i(op), .mem_src_i(src),
    .mem_code_in_ee_i(code_ee), .copy_mode_i(3'h1), .mem_grant_o(mgnt),
    .mem_paddr_o(paddr), .sfr_req_i(sreq), .sfr_addr_i(saddr),
    .sfr_wr_i(swr), .sfr_grant_o(sgnt), .exc_o(exc));
  task automatic compare(input logic [18:0] seen, input logic [18:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : compare
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    mbac_cpu_model_inst.idle();
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    mbac_cpu_model_inst.idle();
    reg_wr_i <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [15:0] d);
    mbac_cpu_model_inst.idle();
    rd_q.push_back(d);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    mbac_cpu_model_inst.idle();
    reg_rd_i <= 1'b0;
  endtask : rreg
  task automatic m(input logic [15:0] a, input logic [1:0] o,
                   input logic [1:0] s, input logic ok);
    note_q.push_back({ok, 1'b0, ~ok, ok ? a + ofs : 16'h0000});
    mbac_cpu_model_inst.mem(a, o, s);
  endtask : m
  task automatic c(input logic [7:0] a, input logic wr, input logic ok);
    note_q.push_back({1'b0, ok, ~ok, 16'h0000});
    mbac_cpu_model_inst.sfr(a, wr);
  endtask : c
  // Results are paired with the oldest note as they appear.
  always @(posedge clock_i) begin
    rd_d <= reg_rd_i;
    if (rd_d) compare({3'h0, rdata}, {3'h0, rd_q.pop_front()});
    if ((mgnt | sgnt | exc) === 1'b1)
      compare({mgnt, sgnt, exc, paddr}, note_q.pop_front());
  end
  initial begin
    #5000;
    n_mismatch++;
    summarize();
  end
  initial begin
    void'($urandom(79106));
    ofs = 16'h0000;
    r = 8'($urandom);
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rreg(8'h00, 16'h0000);
    rreg(8'h2F, 16'h0000);
    m({8'h0F, r}, OX, CP, 1);
    m({8'h10, r}, OR, CP, 0);
    m({8'h87, r}, OW, CP, 1);
    m({8'h88, r}, OR, CP, 1);
    m({8'h88, r}, OW, CP, 0);
    m({8'hE3, r}, OW, CP, 1);
    m({8'hE4, r}, OR, CP, 0);
    m({8'hE3, r}, OX, CP, 0);
    wreg(8'h00, 16'h0005);
    rreg(8'h00, 16'h0000);
    $display("boot test done");
    wreg(8'h00, 16'h0001);
    m({8'h7F, r}, OR, CP, 1);
    m({8'h7F, r}, OW, CP, 0);
    m({8'hDF, r}, OX, CP, 1);
    m({8'hFF, r}, OW, CP, 1);
    wreg(8'h01, 16'h0007);
    code_ee <= 1'b1;
    m({8'h7F, r}, OR, CP, 0);
    m({8'h7F, r}, OR, CY, 0);
    code_ee <= 1'b0;
    m({8'hC0, r}, OR, CY, 0);
    wreg(8'h01, 16'h0000);
    m({8'h7F, r}, OR, CY, 1);
    m({8'hF1, r}, OW, CR, 1);
    m({8'hE8, r}, OR, CR, 0);
    $display("test mode done");
    wreg(8'h00, 16'h0002);
    m({8'h1F, r}, OX, CP, 1);
    m({8'h0F, r}, OR, CP, 0);
    m({8'hC0, r}, OW, CP, 1);
    m({8'h80, r}, OX, CP, 0);
    wreg(8'h02, 16'h0004);
    m({8'h80, r}, OX, CP, 1);
    m({8'h88, r}, OR, CP, 1);
    wreg(8'h03, 16'hE800);
    wreg(8'h05, 16'h0100);
    m({8'hE8, r}, OW, CP, 1);
    m({8'hE9, r}, OW, CP, 0);
    m({8'hE8, r}, OX, CP, 0);
    c(8'h21, 1'b0, 1);
    c(8'h21, 1'b1, 0);
    c(8'h31, 1'b1, 1);
    c(8'h51, 1'b0, 0);
    wreg(8'h02, 16'h0008);
    c(8'h51, 1'b1, 1);
    $display("firmware mode done");
    wreg(8'h00, 16'h0003);
    m({8'h40, r}, OR, CP, 1);
    m({8'h10, r}, OR, CP, 0);
    m({8'hC0, r}, OX, CP, 1);
    m({8'h80, r}, OR, CP, 0);
    m({8'hE8, r}, OW, CP, 1);
    m({8'hE8, r}, OX, CP, 0);
    c(8'h01, 1'b1, 1);
    c(8'h41, 1'b0, 0);
    c(8'h5E, 1'b1, 0);
    c(8'h5E, 1'b0, 1);
    c(8'h5F, 1'b0, 0);
    $display("system mode done");
    wreg(8'h07, 16'h0000);
    wreg(8'h08, 16'h0100);
    wreg(8'h09, 16'h01FF);
    wreg(8'h0A, 16'h8F00);
    wreg(8'h0B, 16'h0001);
    wreg(8'h07, 16'h0001);
    wreg(8'h08, 16'h0200);
    wreg(8'h09, 16'h02FF);
    wreg(8'h00, 16'h0004);
    ofs = 16'h8F00;
    m({8'h01, r}, OR, CP, 1);
    m({8'h01, r}, OW, CP, 0);
    ofs = 16'h0000;
    m({8'h02, r}, OR, CP, 0);
    m({8'h50, r}, OR, CP, 0);
    c(8'h71, 1'b1, 1);
    c(8'h01, 1'b0, 0);
    rreg(8'h0C, 16'h0040);
    rreg(8'h0C, 16'h0000);
    repeat (3) mbac_cpu_model_inst.idle();
    compare(19'(note_q.size()), 19'h0);
    $display("user mode done");
    summarize();
  end
endmodule : tb
